// File: include/aswp_pkg.sv
`default_nettype none
package aswp_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// write cycle and strobe figures in ns
	localparam int WRITE_CYCLE_NS = 70;
	localparam int WRITE_PULSE_NS = 55;
	// width-change and power-down guard figures in ms, power-down setup in ns
	localparam int WIDTH_GUARD_MS = 5;
	localparam int PD_RECOVERY_MS = 5;
	localparam int PD_SETUP_NS = 0;
	// least times round up to whole cycles
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ms counts exceed 4096 cycles and therefore reach the top as parameters
	localparam int WIDTH_GUARD_CYC = (WIDTH_GUARD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PD_RECOVERY_CYC = (PD_RECOVERY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int CNT_W = 24;
	localparam logic [2:0] RST_STATE = 3'h0;
	typedef enum logic [2:0] {
		ASWP_IDLE = 3'b000,
		ASWP_SETUP = 3'b001,
		ASWP_STROBE = 3'b010,
		ASWP_TAIL = 3'b011,
		ASWP_GUARD = 3'b100,
		ASWP_PDOWN = 3'b101
	} aswp_state_t;
endpackage
`default_nettype wire

// File: core/aswp_timer.sv
`timescale 1ns/10ps
`default_nettype none
module aswp_timer (
	input wire logic clock, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic load, // start a countdown
	input wire logic [23:0] value, // cycles to count
	output logic done // high while count is zero and load is low
);
	logic [23:0] cnt_q;
	logic [23:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = value;
		end else if (cnt_q != 24'h000000) begin
			cnt_d = cnt_q - 24'h000001;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_q <= 24'h000000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign done = (cnt_q == 24'h000000) && !load;
endmodule // aswp_timer
`default_nettype wire

// File: core/aswp_host.sv
// Function
// - each write cycle spans at least 70 ns before the next cycle begins
// - write strobe stays low at least 55 ns in every write
// - never drive the data pins while the memory drives them
// - width select change is guarded by 5 ms on both sides
// - after power-down ends wait 5 ms before resuming; deselect needs no setup
// - next cycle may follow as soon as write strobe deasserts
`timescale 1ns/10ps
`default_nettype none
module aswp_host #(
	parameter int WIDTH_GUARD = aswp_pkg::WIDTH_GUARD_CYC, // width guard in cycles
	parameter int PD_RECOVERY = aswp_pkg::PD_RECOVERY_CYC // power-down recovery in cycles
) (
	input wire logic clock, // 100 MHz clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic wr_valid, // write request
	output logic wr_ready, // request taken this cycle
	input wire logic [19:0] wr_addr, // byte address in byte mode, word address [18:0] in word mode
	input wire logic [15:0] wr_data, // write data
	input wire logic [1:0] wr_lanes, // lane enables, bit0 lower
	input wire logic byte_mode_req, // requested organisation, 1 = byte
	input wire logic pd_req, // hold memory in power-down
	output logic busy, // not idle, or idle between the two width guards
	output logic byte_mode, // width select state
	output logic [18:0] mem_addr, // memory address pins
	output logic mem_addr_low, // extra low address bit for byte mode
	output logic chip_select_low_n, // select, active low
	output logic chip_select_high, // select, active high
	output logic lower_lane_strobe_n, // lower lane strobe
	output logic upper_lane_strobe_n, // upper lane strobe
	output logic write_strobe_n, // write strobe
	output logic output_enable_n, // output enable
	output logic width_select_n, // width select, low = byte
	output logic [15:0] data_pins_o, // data out
	output logic data_pins_oe, // high while driving data pins
	input wire logic [15:0] data_pins_i // data in, unused for writes
);
	aswp_pkg::aswp_state_t st_q, st_d;
	logic [18:0] addr_q, addr_d;
	logic alow_q, alow_d;
	logic [15:0] dat_q, dat_d;
	logic [1:0] lane_q, lane_d;
	logic sel_q, sel_d;
	logic we_q, we_d;
	logic oe_q, oe_d;
	logic bm_q, bm_d;
	logic pend_q, pend_d;
	logic tload;
	logic [23:0] tval;
	logic tdone;

	aswp_timer u_timer (
		.clock(clock),
		.sys_rst(sys_rst),
		.load(tload),
		.value(tval),
		.done(tdone)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		alow_d = alow_q;
		dat_d = dat_q;
		lane_d = lane_q;
		sel_d = sel_q;
		we_d = we_q;
		oe_d = oe_q;
		bm_d = bm_q;
		pend_d = pend_q;
		tload = 1'b0;
		tval = 24'h000000;
		wr_ready = 1'b0;
		unique case (st_q)
			aswp_pkg::ASWP_IDLE: begin
				pend_d = 1'b0;
				if (pd_req) begin
					// deselect at once, zero setup is allowed
					sel_d = 1'b0;
					st_d = aswp_pkg::ASWP_PDOWN;
				end else if (byte_mode_req != bm_q) begin
					// first pass only waits out the guard before the flip; second pass flips, then guards after it
					pend_d = !pend_q;
					bm_d = pend_q ? byte_mode_req : bm_q;
					tload = 1'b1;
					tval = WIDTH_GUARD[23:0];
					st_d = aswp_pkg::ASWP_GUARD;
				end else if (wr_valid && tdone) begin
					wr_ready = 1'b1;
					addr_d = bm_q ? wr_addr[19:1] : wr_addr[18:0];
					alow_d = bm_q ? wr_addr[0] : 1'b0;
					dat_d = bm_q ? {8'h00, wr_data[7:0]} : wr_data;
					// byte mode needs both strobes low
					lane_d = bm_q ? 2'h3 : wr_lanes;
					sel_d = 1'b1;
					oe_d = 1'b1;
					st_d = aswp_pkg::ASWP_SETUP;
				end
			end
			aswp_pkg::ASWP_SETUP: begin
				// strobe falls a cycle after select so the write starts only once the memory is selected
				we_d = 1'b1;
				tload = 1'b1;
				tval = 24'(aswp_pkg::WRITE_PULSE_CYC);
				st_d = aswp_pkg::ASWP_STROBE;
			end
			aswp_pkg::ASWP_STROBE: begin
				if (tdone) begin
					we_d = 1'b0;
					st_d = aswp_pkg::ASWP_TAIL;
				end
			end
			aswp_pkg::ASWP_TAIL: begin
				// release pins one cycle after the strobe rises; no recovery needed
				sel_d = 1'b0;
				oe_d = 1'b0;
				lane_d = 2'h0;
				st_d = aswp_pkg::ASWP_IDLE;
			end
			aswp_pkg::ASWP_GUARD: begin
				if (tdone) begin
					st_d = aswp_pkg::ASWP_IDLE;
				end
			end
			aswp_pkg::ASWP_PDOWN: begin
				if (!pd_req) begin
					tload = 1'b1;
					tval = PD_RECOVERY[23:0];
					st_d = aswp_pkg::ASWP_GUARD;
				end
			end
			default: begin
				st_d = aswp_pkg::ASWP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_q <= aswp_pkg::ASWP_IDLE;
			addr_q <= 19'h00000;
			alow_q <= 1'b0;
			dat_q <= 16'h0000;
			lane_q <= 2'h0;
			sel_q <= 1'b0;
			we_q <= 1'b0;
			oe_q <= 1'b0;
			bm_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			alow_q <= alow_d;
			dat_q <= dat_d;
			lane_q <= lane_d;
			sel_q <= sel_d;
			we_q <= we_d;
			oe_q <= oe_d;
			bm_q <= bm_d;
			pend_q <= pend_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output enable held high: the controller never reads, so the memory never drives
	assign output_enable_n = 1'b1;
	assign chip_select_low_n = !sel_q;
	assign chip_select_high = sel_q;
	assign lower_lane_strobe_n = !lane_q[0];
	assign upper_lane_strobe_n = !lane_q[1];
	assign write_strobe_n = !we_q;
	assign mem_addr = addr_q;
	assign mem_addr_low = alow_q;
	assign data_pins_o = dat_q;
	assign data_pins_oe = oe_q;
	assign width_select_n = !bm_q;
	assign byte_mode = bm_q;
	// stays high in the idle cycle between the two width guards
	assign busy = (st_q != aswp_pkg::ASWP_IDLE) || pend_q;

	////////////////////////////////////////////////////////////////////////////////
	int unsigned cyc_q;
	always_ff @(posedge clock) begin
		if (sys_rst || wr_ready) begin
			cyc_q <= 0;
		end else if (cyc_q < 1000) begin
			cyc_q <= cyc_q + 1;
		end
	end

	sequence s_strobe_low;
		!write_strobe_n [*6];
	endsequence

	a_strobe_width: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(write_strobe_n) |-> s_strobe_low) else $error("write strobe too short");
	a_cycle_span: assert property (@(posedge clock) disable iff (sys_rst)
		wr_ready && $past(busy) |-> cyc_q >= 7) else $error("write cycle too short");
	a_strobe_selected: assert property (@(posedge clock) disable iff (sys_rst)
		!write_strobe_n |-> !chip_select_low_n && chip_select_high && data_pins_oe) else $error("strobe unselected");
	a_select_first: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(write_strobe_n) |-> $past(chip_select_high)) else $error("strobe before select");
	a_no_contention: assert property (@(posedge clock) disable iff (sys_rst)
		data_pins_oe |-> output_enable_n) else $error("data pin contention");
	a_width_hold: assert property (@(posedge clock) disable iff (sys_rst)
		$changed(width_select_n) |-> !chip_select_high [*8]) else $error("access near width change");
	a_pd_deselect: assert property (@(posedge clock) disable iff (sys_rst)
		st_q == aswp_pkg::ASWP_PDOWN |-> !chip_select_high && chip_select_low_n) else $error("selected in power-down");
	a_release_fast: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(write_strobe_n) |-> busy ##1 !chip_select_high && !busy) else $error("slow release");
	a_byte_lanes: assert property (@(posedge clock) disable iff (sys_rst)
		!chip_select_low_n && byte_mode |-> !lower_lane_strobe_n && !upper_lane_strobe_n) else $error("byte lanes");
endmodule // aswp_host
`default_nettype wire

// File: sim/aswp_sram_model.sv
`timescale 1ns/10ps
`default_nettype none
module aswp_sram_model (
	input wire logic [18:0] mem_addr, // address pins
	input wire logic mem_addr_low, // byte pick in byte mode
	input wire logic chip_select_low_n, // select, active low
	input wire logic chip_select_high, // select, active high
	input wire logic lower_lane_strobe_n, // lower lane strobe
	input wire logic upper_lane_strobe_n, // upper lane strobe
	input wire logic write_strobe_n, // write strobe
	input wire logic output_enable_n, // output enable
	input wire logic width_select_n, // low = byte
	input wire logic [15:0] data_pins_o, // host data
	input wire logic data_pins_oe, // host drives data
	output logic [15:0] data_pins_i // memory data
);
	logic [15:0] mem [0:255];
	logic sel;
	logic driving;
	realtime t_fall;
	int viol;
	initial begin
		viol = 0;
		t_fall = -1000.0;
	end
	assign sel = !chip_select_low_n && chip_select_high && !(lower_lane_strobe_n && upper_lane_strobe_n);
	// reads only; a write keeps the pins floating, shown as inverted host data
	assign driving = sel && write_strobe_n && !output_enable_n;
	assign data_pins_i = driving ? mem[mem_addr[7:0]] : ~data_pins_o;
	always @(driving or data_pins_oe) begin
		if (driving && data_pins_oe) viol++;
	end
	always @(negedge write_strobe_n) begin
		if (!sel) viol++;
		if ($realtime - t_fall < 70.0) viol++;
		t_fall = $realtime;
	end
	always @(posedge write_strobe_n) begin
		if ($realtime - t_fall < 55.0) viol++;
		if (sel && !width_select_n) begin
			if (mem_addr_low) mem[mem_addr[7:0]][15:8] = data_pins_o[7:0];
			else mem[mem_addr[7:0]][7:0] = data_pins_o[7:0];
		end else if (sel) begin
			if (!lower_lane_strobe_n) mem[mem_addr[7:0]][7:0] = data_pins_o[7:0];
			if (!upper_lane_strobe_n) mem[mem_addr[7:0]][15:8] = data_pins_o[15:8];
		end
	end
endmodule // aswp_sram_model
`default_nettype wire

// File: sim/async_sram_write_powerdown_test.sv
`timescale 1ns/10ps
`default_nettype none
module async_sram_write_powerdown_test;
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin failures++; \
	$display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
	logic clock, sys_rst, wr_valid, wr_ready, byte_mode_req, pd_req, busy, byte_mode, mem_addr_low;
	logic chip_select_low_n, chip_select_high, lower_lane_strobe_n, upper_lane_strobe_n;
	logic write_strobe_n, output_enable_n, width_select_n, data_pins_oe;
	logic [19:0] wr_addr;
	logic [18:0] mem_addr;
	logic [15:0] wr_data, data_pins_o, data_pins_i;
	logic [1:0] wr_lanes;
	int failures, comparisons, cyc, n, c0;
	aswp_host #(.WIDTH_GUARD(20), .PD_RECOVERY(20)) dut (.clock(clock), .sys_rst(sys_rst),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_lanes(wr_lanes), .byte_mode_req(byte_mode_req), .pd_req(pd_req), .busy(busy),
		.byte_mode(byte_mode), .mem_addr(mem_addr), .mem_addr_low(mem_addr_low),
		.chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high),
		.lower_lane_strobe_n(lower_lane_strobe_n), .upper_lane_strobe_n(upper_lane_strobe_n),
		.write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
		.width_select_n(width_select_n), .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe),
		.data_pins_i(data_pins_i));
	aswp_sram_model sram (.mem_addr(mem_addr), .mem_addr_low(mem_addr_low),
		.chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high),
		.lower_lane_strobe_n(lower_lane_strobe_n), .upper_lane_strobe_n(upper_lane_strobe_n),
		.write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
		.width_select_n(width_select_n), .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe),
		.data_pins_i(data_pins_i));
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) cyc++;
	////////////////////////////////////////////////////////////////
	task stop_test;
		$display("counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task wait_busy(input int lim);
		n = 0;
		while (busy !== 1'b0 && n < lim) begin @(negedge clock); n++; end
		if (busy !== 1'b0) failures++;
	endtask
	// bounded wait, so a stuck handshake adds one to the failure count
	task wait_ready;
		n = 0;
		#1;
		while (wr_ready !== 1'b1 && n < 100) begin @(negedge clock); #1; n++; end
		if (wr_ready !== 1'b1) failures++;
	endtask
	task t_reset;
		@(negedge clock);
		sys_rst = 1;
		@(negedge clock);
		sys_rst = 0;
		`CHK("rst busy", 1'b0, busy)
		`CHK("rst sel", 2'b10, {chip_select_low_n, chip_select_high})
		`CHK("rst strobes", 4'hf, {write_strobe_n, lower_lane_strobe_n, upper_lane_strobe_n, output_enable_n})
		`CHK("rst drive", 1'b0, data_pins_oe)
		`CHK("rst width", 2'b01, {byte_mode, width_select_n})
		$display("test reset done");
	endtask
	task do_write(input logic [19:0] a, input logic [15:0] d, input logic [1:0] l);
		@(negedge clock);
		wr_valid = 1;
		wr_addr = a;
		wr_data = d;
		wr_lanes = l;
		wait_ready;
		@(negedge clock);
		wr_valid = 0;
		wait_busy(100);
	endtask
	////////////////////////////////////////////////////////////////
	task t_word;
		do_write(20'h00002, 16'h1234, 2'b11);
		`CHK("word", 16'h1234, sram.mem[2])
		do_write(20'h00003, 16'haaaa, 2'b11);
		do_write(20'h00003, 16'h5566, 2'b01);
		`CHK("lower lane", 16'haa66, sram.mem[3])
		do_write(20'h00003, 16'h7788, 2'b10);
		`CHK("upper lane", 16'h7766, sram.mem[3])
		`CHK("deselect", 1'b1, chip_select_low_n)
		$display("test word done");
	endtask
	task t_b2b;
		do_write(20'h00004, 16'h1111, 2'b11);
		@(negedge clock);
		wr_valid = 1;
		wr_addr = 20'h00004;
		wr_data = 16'h2222;
		wr_lanes = 2'b11;
		wait_ready;
		c0 = cyc;
		@(negedge clock);
		wr_addr = 20'h00005;
		wr_data = 16'h3333;
		wait_ready;
		// setup, seven strobe-low cycles, tail, then release
		`CHK("spacing", 10, cyc - c0)
		@(negedge clock);
		wr_valid = 0;
		wait_busy(100);
		`CHK("b2b first", 16'h2222, sram.mem[4])
		`CHK("b2b data", 16'h3333, sram.mem[5])
		$display("test back to back done");
	endtask
	task t_byte;
		@(negedge clock);
		byte_mode_req = 1;
		@(negedge clock);
		wait_busy(100);
		`CHK("guard", 1'b1, n >= 40)
		`CHK("width pin", 1'b0, width_select_n)
		`CHK("byte mode", 1'b1, byte_mode)
		do_write(20'h00005, 16'hffab, 2'b00);
		`CHK("byte write", 16'hab34, sram.mem[2])
		@(negedge clock);
		byte_mode_req = 0;
		@(negedge clock);
		wait_busy(100);
		`CHK("word again", 1'b1, width_select_n)
		`CHK("word mode", 1'b0, byte_mode)
		$display("test byte done");
	endtask
	task t_pd;
		@(negedge clock);
		pd_req = 1;
		wr_valid = 1;
		wr_addr = 20'h00006;
		wr_data = 16'h9999;
		wr_lanes = 2'b11;
		repeat (5) begin @(negedge clock); `CHK("pd refuse", 1'b0, wr_ready) end
		`CHK("pd sel", 2'b10, {chip_select_low_n, chip_select_high})
		pd_req = 0;
		wait_ready;
		`CHK("recovery", 1'b1, n >= 20)
		@(negedge clock);
		wr_valid = 0;
		wait_busy(100);
		`CHK("pd data", 16'h9999, sram.mem[6])
		$display("test power down done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{failures, comparisons, cyc} = '0;
		{sys_rst, wr_valid, byte_mode_req, pd_req} = 4'h8;
		wr_addr = '0;
		wr_data = '0;
		wr_lanes = '0;
		repeat (8) @(negedge clock);
		sys_rst = 0;
		t_reset;
		t_word;
		t_b2b;
		t_byte;
		t_reset;
		t_pd;
		`CHK("memory timing", 0, sram.viol)
		stop_test;
	end
	initial begin
		#200000;
		failures++;
		stop_test;
	end
endmodule // async_sram_write_powerdown_test
`default_nettype wire
